/* rf_proximity_frame_cmd_check.sv */
/*
 Tag-side frame receiver, poll responder and service/block list checker.
 Assumes decoded bits with a strobe from an asynchronous demodulator, and a
 downstream command body that acts on chk_done with status 00/00.
*/
`timescale 1ns/10ps
`include "rfp_defs.svh"
module rf_proximity_frame_cmd_check #(
    parameter int MAXLEN     = 128,
    parameter int MEM_BLOCKS = 32
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Decoded receive bits (pins)
    input  wire logic        rx_bit_pin,
    input  wire logic        rx_stb_pin,
    // Stored parameters
    input  wire logic [15:0] stored_system_code,
    input  wire logic [63:0] card_identifier_area,
    input  wire logic [15:0] response_time_params,
    input  wire logic        rate_424,
    // Load modulation output
    output logic             tx_out_r,
    output logic             tx_active_r,
    // Check results
    output logic             chk_done_r,
    output logic [7:0]       chk_status1_r,
    output logic [7:0]       chk_status2_r,
    output logic             chk_tunnel_r,
    output logic             frame_drop_r
);
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? `CRC_POLY : 16'h0000);
        end
        return r;
    endfunction

    // Input synchronisers, first stage read only by second
    logic [1:0] bit_s_r, stb_s_r;
    logic       stb_d_r;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bit_s_r <= 2'h0;
            stb_s_r <= 2'h0;
            stb_d_r <= 1'b0;
        end else begin
            bit_s_r <= {bit_s_r[0], rx_bit_pin};
            stb_s_r <= {stb_s_r[0], rx_stb_pin};
            stb_d_r <= stb_s_r[1];
        end
    end
    wire logic bit_in = bit_s_r[1];
    wire logic bit_ev = stb_s_r[1] & ~stb_d_r;

    rfp_pkg::state_t st_r, st_nxt;
    logic [7:0]  buf_r [MAXLEN];
    logic [15:0] sh_r, sh_nxt, crc_r, crc_nxt;
    logic [2:0]  bc_r, bc_nxt, mode_r, mode_nxt;
    logic [7:0]  len_r, len_nxt, cnt_r, cnt_nxt, ptr_r, ptr_nxt, nb_r, nb_nxt, prev_r, prev_nxt;
    logic [7:0]  s2_r, s2_nxt, tn_r, tn_nxt, k_r, k_nxt;
    logic        is_poll_r, is_poll_nxt, we;
    logic [8:0]  half_r, half_nxt;
    logic        ph_r, ph_nxt, tx_nxt, act_nxt, done_nxt, drop_nxt, tun_nxt;
    logic [7:0]  s1_nxt, s2o_nxt;

    wire logic [7:0] rx_byte = {sh_r[6:0], bit_in};
    wire logic [7:0] cmd = buf_r[0];
    wire logic [15:0] req_sc = {buf_r[1], buf_r[2]};
    wire logic is_wr = (cmd == `CMD_WRITE);
    wire logic [7:0] max_svc = is_wr ? `MAX_SVC_WR : `MAX_SVC_RD;
    wire logic poll_hit = (req_sc == `POLL_ALL)
        || (req_sc == `POLL_CLASS && stored_system_code[15:8] == `CLASS_HI)
        || (req_sc == stored_system_code);
    // Block element view at ptr
    wire logic [7:0] e0 = buf_r[ptr_r[6:0]];
    wire logic [7:0] bn = buf_r[7'(ptr_r + 8'h01)];
    wire logic [7:0] e2 = e0[7] ? 8'h00 : buf_r[7'(ptr_r + 8'h02)];
    wire logic [2:0] md = e2[2:0];
    wire logic first = (cnt_r == 8'h00);
    wire logic [7:0] max_blk = !is_wr ? ((mode_r == `MODE_TUNNEL) ? `MAX_BLK_RD_TN
        : `MAX_BLK_RD_RF) : ((buf_r[9] > `SVC_SPLIT) ? `MAX_BLK_WR_HI : `MAX_BLK_WR_LO);
    wire logic blk_bad = (e0[6:4] != 3'h0)
        || (e2[7:3] != 5'h00)
        || (md != `MODE_RF && md != `MODE_TUNNEL)
        || (!first && md != mode_r)
        || (!first && md == `MODE_TUNNEL && bn != 8'(prev_r + 8'h01))
        || (md == `MODE_RF && {24'h0, bn} >= MEM_BLOCKS);

    // Response frame byte k
    logic [7:0] tx_byte, dbyte, j;
    always_comb begin
        j = 8'(k_r - 8'h09);
        if (is_poll_r) begin
            unique case (j)
                8'h00:                      dbyte = `RSP_POLL;
                8'h09, 8'h0a, 8'h10:        dbyte = 8'hff;
                8'h0e:                      dbyte = response_time_params[15:8];
                8'h0f:                      dbyte = response_time_params[7:0];
                8'h0b, 8'h0c, 8'h0d:        dbyte = 8'h00;
                default:                    dbyte = card_identifier_area[8'(8'h08 - j) * 8 +: 8];
            endcase
        end else begin
            unique case (j)
                8'h00:   dbyte = 8'(cmd + 8'h01);
                8'h09:   dbyte = `ST_FAIL;
                8'h0a:   dbyte = s2_r;
                default: dbyte = card_identifier_area[8'(8'h08 - j) * 8 +: 8];
            endcase
        end
        if (k_r < `PREAMBLE_BYTES)          tx_byte = 8'h00;
        else if (k_r == 8'h06)              tx_byte = 8'(`SYNC_CODE >> 8);
        else if (k_r == 8'h07)              tx_byte = 8'(`SYNC_CODE & 16'h00ff);
        else if (k_r == 8'h08)              tx_byte = 8'(tn_r + 8'h01);
        else if (k_r == 8'(tn_r + 8'h09))   tx_byte = crc_r[15:8];
        else if (k_r == 8'(tn_r + 8'h0a))   tx_byte = crc_r[7:0];
        else                                tx_byte = dbyte;
    end

    always_comb begin
        st_nxt = st_r; sh_nxt = sh_r; crc_nxt = crc_r; bc_nxt = bc_r; mode_nxt = mode_r;
        len_nxt = len_r; cnt_nxt = cnt_r; ptr_nxt = ptr_r; nb_nxt = nb_r; prev_nxt = prev_r;
        s2_nxt = s2_r; tn_nxt = tn_r; k_nxt = k_r; is_poll_nxt = is_poll_r; we = 1'b0;
        half_nxt = half_r; ph_nxt = ph_r; tx_nxt = tx_out_r; act_nxt = 1'b0;
        done_nxt = 1'b0; drop_nxt = 1'b0; tun_nxt = chk_tunnel_r;
        s1_nxt = chk_status1_r; s2o_nxt = chk_status2_r;
        if (bit_ev && st_r <= rfp_pkg::S_CRC) begin
            sh_nxt = {sh_r[14:0], bit_in};
            bc_nxt = 3'(bc_r + 3'h1);
        end
        unique case (st_r)
            rfp_pkg::S_HUNT: if (bit_ev && sh_nxt == `SYNC_CODE) begin
                st_nxt = rfp_pkg::S_LEN;
                bc_nxt = 3'h0;
            end
            rfp_pkg::S_LEN: if (bit_ev && bc_r == 3'h7) begin
                len_nxt = rx_byte;
                crc_nxt = crc_upd(`CRC_INIT, rx_byte);
                cnt_nxt = 8'h00;
                if (rx_byte < 8'h02 || {24'h0, rx_byte} > MAXLEN) begin
                    st_nxt = rfp_pkg::S_HUNT;
                    drop_nxt = 1'b1;
                end else st_nxt = rfp_pkg::S_DATA;
            end
            rfp_pkg::S_DATA: if (bit_ev && bc_r == 3'h7) begin
                we = 1'b1;
                crc_nxt = crc_upd(crc_r, rx_byte);
                cnt_nxt = 8'(cnt_r + 8'h01);
                if (cnt_nxt == 8'(len_r - 8'h01)) begin
                    st_nxt = rfp_pkg::S_CRC;
                    cnt_nxt = 8'h00;
                end
            end
            rfp_pkg::S_CRC: if (bit_ev && bc_r == 3'h7) begin
                crc_nxt = crc_upd(crc_r, rx_byte);
                cnt_nxt = 8'(cnt_r + 8'h01);
                if (cnt_r == 8'h01) begin
                    // Residue over length, data plus code is zero when intact
                    st_nxt = (crc_nxt == 16'h0000) ? rfp_pkg::S_EXEC : rfp_pkg::S_HUNT;
                    drop_nxt = (crc_nxt != 16'h0000);
                    sh_nxt = 16'h0000;
                end
            end
            rfp_pkg::S_EXEC: begin
                st_nxt = rfp_pkg::S_HUNT;
                is_poll_nxt = (cmd == `CMD_POLL);
                if (cmd == `CMD_POLL && len_r == 8'(`POLL_DLEN + 8'h01) && poll_hit) begin
                    tn_nxt = `RSP_POLL_DLEN;
                    st_nxt = rfp_pkg::S_TX;
                end else if (cmd == `CMD_READ || is_wr) begin
                    st_nxt = rfp_pkg::S_DONE;
                    s2_nxt = `ST_SVC_CNT;
                    if (buf_r[9] != 8'h00 && buf_r[9] <= max_svc) begin
                        st_nxt = rfp_pkg::S_SVC;
                        ptr_nxt = 8'h0c;
                        cnt_nxt = 8'h01;
                    end
                end
            end
            rfp_pkg::S_SVC: begin
                if (cnt_r == buf_r[9]) begin
                    nb_nxt = buf_r[ptr_r[6:0]];
                    ptr_nxt = 8'(ptr_r + 8'h01);
                    cnt_nxt = 8'h00;
                    st_nxt = rfp_pkg::S_BLK;
                    s2_nxt = `ST_BLK_CNT;
                    if (nb_nxt == 8'h00 || nb_nxt > `MAX_BLK_RD_TN) st_nxt = rfp_pkg::S_DONE;
                end else if ({buf_r[ptr_r[6:0]], buf_r[7'(ptr_r + 8'h01)]}
                             != {buf_r[10], buf_r[11]}) begin
                    s2_nxt = `ST_SVC_DIFF;
                    st_nxt = rfp_pkg::S_DONE;
                end else begin
                    ptr_nxt = 8'(ptr_r + 8'h02);
                    cnt_nxt = 8'(cnt_r + 8'h01);
                end
            end
            rfp_pkg::S_BLK: begin
                if (blk_bad) begin
                    s2_nxt = `ST_BLK_SPEC;
                    st_nxt = rfp_pkg::S_DONE;
                end else begin
                    mode_nxt = md;
                    prev_nxt = bn;
                    ptr_nxt = 8'(ptr_r + (e0[7] ? 8'h02 : 8'h03));
                    cnt_nxt = 8'(cnt_r + 8'h01);
                    if (cnt_nxt == nb_r) begin
                        st_nxt = rfp_pkg::S_DONE;
                        s2_nxt = (nb_r > ((md == `MODE_TUNNEL && !is_wr) ? `MAX_BLK_RD_TN
                            : (first ? max_blk : max_blk))) ? `ST_BLK_CNT : `ST_OK;
                    end
                end
            end
            rfp_pkg::S_DONE: begin
                done_nxt = 1'b1;
                tun_nxt = (mode_r == `MODE_TUNNEL);
                s1_nxt = (s2_r == `ST_OK) ? `ST_OK : `ST_FAIL;
                s2o_nxt = s2_r;
                tn_nxt = `RSP_ERR_DLEN;
                st_nxt = (s2_r == `ST_OK) ? rfp_pkg::S_HUNT : rfp_pkg::S_TX;
                k_nxt = 8'h00;
                bc_nxt = 3'h0;
                crc_nxt = `CRC_INIT;
                half_nxt = 9'h000;
                ph_nxt = 1'b0;
            end
            rfp_pkg::S_TX: begin
                act_nxt = 1'b1;
                tx_nxt = tx_byte[3'h7 - bc_r] ^ ph_r;
                half_nxt = 9'(half_r + 9'h001);
                if ({23'h0, half_r} == (rate_424 ? `HALF_HI : `HALF_LO) - 1) begin
                    half_nxt = 9'h000;
                    ph_nxt = ~ph_r;
                    if (ph_r) begin
                        bc_nxt = 3'(bc_r + 3'h1);
                        if (bc_r == 3'h7) begin
                            k_nxt = 8'(k_r + 8'h01);
                            if (k_r >= 8'h08 && k_r <= 8'(tn_r + 8'h08))
                                crc_nxt = crc_upd(crc_r, tx_byte);
                            if (k_r == 8'(tn_r + 8'h0a)) begin
                                st_nxt = rfp_pkg::S_HUNT;
                                act_nxt = 1'b0;
                                tx_nxt = 1'b0;
                            end
                        end
                    end
                end
            end
            default: st_nxt = rfp_pkg::S_HUNT;
        endcase
        if (st_r == rfp_pkg::S_EXEC && st_nxt == rfp_pkg::S_TX) begin
            k_nxt = 8'h00; bc_nxt = 3'h0; crc_nxt = `CRC_INIT; half_nxt = 9'h000; ph_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (we) buf_r[cnt_r[6:0]] <= rx_byte;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= rfp_pkg::S_HUNT; sh_r <= 16'h0000; crc_r <= 16'h0000; bc_r <= 3'h0;
            mode_r <= 3'h0; len_r <= 8'h00; cnt_r <= 8'h00; ptr_r <= 8'h00; nb_r <= 8'h00;
            prev_r <= 8'h00; s2_r <= 8'h00; tn_r <= 8'h00; k_r <= 8'h00; is_poll_r <= 1'b0;
            half_r <= 9'h000; ph_r <= 1'b0; tx_out_r <= 1'b0; tx_active_r <= 1'b0;
            chk_done_r <= 1'b0; chk_status1_r <= 8'h00; chk_status2_r <= 8'h00;
            chk_tunnel_r <= 1'b0; frame_drop_r <= 1'b0;
        end else begin
            st_r <= st_nxt; sh_r <= sh_nxt; crc_r <= crc_nxt; bc_r <= bc_nxt;
            mode_r <= mode_nxt; len_r <= len_nxt; cnt_r <= cnt_nxt; ptr_r <= ptr_nxt;
            nb_r <= nb_nxt; prev_r <= prev_nxt; s2_r <= s2_nxt; tn_r <= tn_nxt; k_r <= k_nxt;
            is_poll_r <= is_poll_nxt; half_r <= half_nxt; ph_r <= ph_nxt;
            tx_out_r <= tx_nxt; tx_active_r <= act_nxt; chk_done_r <= done_nxt;
            chk_status1_r <= s1_nxt; chk_status2_r <= s2o_nxt; chk_tunnel_r <= tun_nxt;
            frame_drop_r <= drop_nxt;
        end
    end

    a_sync_hunt: assert property (@(posedge clock) disable iff (!reset_n)
        st_r == rfp_pkg::S_HUNT && bit_ev && sh_nxt == `SYNC_CODE |=> st_r == rfp_pkg::S_LEN)
        else $error("sync not taken");
    a_poll_all: assert property (@(posedge clock) disable iff (!reset_n)
        st_r == rfp_pkg::S_EXEC && cmd == `CMD_POLL && len_r == 8'h06 && req_sc == `POLL_ALL
        |=> st_r == rfp_pkg::S_TX ##1 tx_active_r) else $error("wildcard poll unanswered");
    a_poll_class: assert property (@(posedge clock) disable iff (!reset_n)
        st_r == rfp_pkg::S_EXEC && cmd == `CMD_POLL && req_sc == `POLL_CLASS
        && stored_system_code[15:8] != `CLASS_HI |=> st_r == rfp_pkg::S_HUNT)
        else $error("class poll answered");
    a_poll_miss: assert property (@(posedge clock) disable iff (!reset_n)
        st_r == rfp_pkg::S_EXEC && cmd == `CMD_POLL && req_sc != stored_system_code
        && req_sc != `POLL_ALL && req_sc != `POLL_CLASS |=> !tx_active_r [*2])
        else $error("mismatched poll answered");
    a_crc_drop: assert property (@(posedge clock) disable iff (!reset_n)
        st_r == rfp_pkg::S_CRC && st_nxt == rfp_pkg::S_HUNT |=> frame_drop_r && !tx_active_r)
        else $error("bad frame not dropped");
    a_svc_count: assert property (@(posedge clock) disable iff (!reset_n)
        st_r == rfp_pkg::S_EXEC && cmd == `CMD_WRITE && buf_r[9] > `MAX_SVC_WR
        |=> ##1 chk_done_r && chk_status2_r == `ST_SVC_CNT) else $error("service count");
    a_fail_pair: assert property (@(posedge clock) disable iff (!reset_n)
        chk_done_r |-> (chk_status1_r == `ST_OK) == (chk_status2_r == `ST_OK))
        else $error("status pair inconsistent");
    a_manch_half: assert property (@(posedge clock) disable iff (!reset_n)
        tx_active_r && $past(tx_active_r) && $rose(ph_r) ##1 1'b1 |-> tx_out_r != $past(tx_out_r))
        else $error("second half not inverted");
endmodule

/* rfp_defs.svh */
/*
 Constants of the proximity frame and command checker: framing, status codes, limits, timing.
 Assumes a 125 MHz system clock and a demodulator that supplies decoded bits with a strobe.
*/
// Overview of operation
// - One command frame in, at most one response frame out.
// - Manchester bits both ways at 212 or 424 kbps.
// - Eight bits per character, MSB first, no framing bits, no gaps.
// - Frame: six zero bytes, sync B24D, length (data+1), data, check code.
// - Poll code FFFF: always answer.
// - Poll code AAFF: answer when stored code upper byte is AA.
// - Other poll codes: answer only on exact match.
// - Poll answer carries the eight-byte card identifier.
// - Timing descriptor: bytes 0,1,7 FF, 2-4 zero, 5-6 stored.
// - Poll answer always goes in the first time slot.
// - Service list holds at most 15 (read) or 11 (write).
// - Differing services in one list give an error.
// - Memory is 16-byte blocks by number, content unstructured.
// - Nonzero access bits 6-4 of element byte 0 give an error.
// - Nonzero bits 7-3 of third element byte give an error.
// - Two-byte element is RF; mode 000 RF, 100 tunnel, others error.
// - Block limits: read 13 RF, 15 tunnel; write 12 or 11.
// - Tunnel block numbers must ascend by one; RF order is free.
// - Ascending order wraps from FF to 00.
// - All listed blocks must share one mode.
// - Block element faults report FF/A5; block count FF/A2.
// - Service count FF/A1, mismatch FF/A3, normal 00/00.
`ifndef RFP_DEFS_SVH
`define RFP_DEFS_SVH
`define SYNC_CODE      16'hb24d
`define PREAMBLE_BYTES 8'h06
`define CRC_POLY       16'h1021
`define CRC_INIT       16'h0000
`define CMD_POLL       8'h00
`define CMD_READ       8'h06
`define CMD_WRITE      8'h08
`define RSP_POLL       8'h01
`define POLL_ALL       16'hffff
`define POLL_CLASS     16'haaff
`define CLASS_HI       8'haa
`define POLL_DLEN      8'h05
`define RSP_POLL_DLEN  8'h11
`define RSP_ERR_DLEN   8'h0b
`define ST_FAIL        8'hff
`define ST_OK          8'h00
`define ST_SVC_CNT     8'ha1
`define ST_BLK_CNT     8'ha2
`define ST_SVC_DIFF    8'ha3
`define ST_BLK_SPEC    8'ha5
`define MAX_SVC_RD     8'h0f
`define MAX_SVC_WR     8'h0b
`define MAX_BLK_RD_RF  8'h0d
`define MAX_BLK_RD_TN  8'h0f
`define MAX_BLK_WR_LO  8'h0c
`define MAX_BLK_WR_HI  8'h0b
`define SVC_SPLIT      8'h08
`define MODE_RF        3'h0
`define MODE_TUNNEL    3'h4
`define CLK_KHZ        125000
`define RATE_LO_KBPS   212
`define RATE_HI_KBPS   424
`define HALF_LO        (`CLK_KHZ / (2 * `RATE_LO_KBPS))
`define HALF_HI        (`CLK_KHZ / (2 * `RATE_HI_KBPS))
`endif

/* rfp_pkg.sv */
/*
 Types of the proximity frame and command checker.
 Assumes nothing beyond the constants header.
*/
package rfp_pkg;
    typedef enum logic [3:0] {
        S_HUNT = 4'h0,
        S_LEN  = 4'h1,
        S_DATA = 4'h2,
        S_CRC  = 4'h3,
        S_EXEC = 4'h4,
        S_SVC  = 4'h5,
        S_BLK  = 4'h6,
        S_DONE = 4'h7,
        S_TX   = 4'h8
    } state_t;
endpackage

/* rfp_reader_model.sv */
/*
 Reader model: frames commands onto the decoded bit pins, decodes the tag's answers.
 Assumes the tag clock and the tag's registered transmit outputs.
*/
`timescale 1ns/10ps
`include "rfp_defs.svh"
module rfp_reader_model (
    // Clock
    input  wire logic clock,
    // Tag receive side
    output logic      rx_bit_pin,
    output logic      rx_stb_pin,
    // Tag transmit side
    input  wire logic tx_out_r,
    input  wire logic tx_active_r,
    input  wire logic rate_424
);
    initial begin
        rx_bit_pin = 1'b0;
        rx_stb_pin = 1'b0;
    end
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? `CRC_POLY : 16'h0000);
        return c;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Bit set a clock ahead of the strobe, held past the synchroniser
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            rx_bit_pin = b[i];
            tick(1);
            rx_stb_pin = 1'b1;
            tick(3);
            rx_stb_pin = 1'b0;
            tick(1);
        end
    endtask
    // One command per call; the caller waits for the answer first
    task automatic send_frame(input logic [7:0] q[$], input logic [15:0] crc_xor);
        logic [15:0] c;
        logic [7:0]  len;
        len = 8'(q.size() + 1);
        c = crc_byte(`CRC_INIT, len);
        foreach (q[i]) c = crc_byte(c, q[i]);
        c = c ^ crc_xor;
        repeat (6) send_byte(8'h00);
        send_byte(8'(`SYNC_CODE >> 8));
        send_byte(8'(`SYNC_CODE));
        send_byte(len);
        foreach (q[i]) send_byte(q[i]);
        send_byte(c[15:8]);
        send_byte(c[7:0]);
        // Released line must not keep its last level
        rx_bit_pin = ~rx_bit_pin;
    endtask
    // Samples mid first half of each Manchester bit
    task automatic rcv(output logic [7:0] rq[$]);
        logic [7:0] b;
        int         half;
        int         n;
        rq = {};
        b = 8'h00;
        n = 0;
        half = rate_424 ? `HALF_HI : `HALF_LO;
        repeat (half / 2) @(posedge clock);
        while (tx_active_r === 1'b1) begin
            b = {b[6:0], tx_out_r};
            n++;
            if (n % 8 == 0) rq.push_back(b);
            repeat (2 * half) @(posedge clock);
        end
    endtask
endmodule

/* rf_proximity_frame_cmd_check_bench.sv */
/*
 Self-checking bench for the proximity frame checker: poll answers, list checks, drops.
 Assumes the reader model and the design's constants header.
*/
`timescale 1ns/10ps
`include "rfp_defs.svh"
module rf_proximity_frame_cmd_check_bench;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        rate_424 = 1'b1;
    logic [15:0] stored_system_code = 16'h1234;
    logic [63:0] card_identifier_area = 64'h0123456789abcdef;
    logic [15:0] response_time_params = 16'h5a3c;
    logic        rx_bit_pin, rx_stb_pin, tx_out_r, tx_active_r;
    logic        chk_done_r, chk_tunnel_r, frame_drop_r;
    logic [7:0]  chk_status1_r, chk_status2_r;
    logic [7:0]  q[$];
    int          err_total = 0;
    int          n_tests = 0;
    int          drops = 0;
    always #4 clock = ~clock;
    // Drop pulse may land while the frame tail is still going out
    always @(posedge clock) if (frame_drop_r === 1'b1) drops++;
    rf_proximity_frame_cmd_check rf_proximity_frame_cmd_check_inst (
        .clock(clock), .reset_n(reset_n), .rx_bit_pin(rx_bit_pin), .rx_stb_pin(rx_stb_pin),
        .stored_system_code(stored_system_code), .card_identifier_area(card_identifier_area),
        .response_time_params(response_time_params), .rate_424(rate_424),
        .tx_out_r(tx_out_r), .tx_active_r(tx_active_r), .chk_done_r(chk_done_r),
        .chk_status1_r(chk_status1_r), .chk_status2_r(chk_status2_r),
        .chk_tunnel_r(chk_tunnel_r), .frame_drop_r(frame_drop_r));
    rfp_reader_model reader_inst (
        .clock(clock), .rx_bit_pin(rx_bit_pin), .rx_stb_pin(rx_stb_pin),
        .tx_out_r(tx_out_r), .tx_active_r(tx_active_r), .rate_424(rate_424));
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Cuts short any answer frame, far too long to sit through each time
    task automatic pulse_reset();
        reset_n = 1'b0;
        tick(2);
        reset_n = 1'b1;
        tick(3);
    endtask
    task automatic watch(input int sel, input int lim, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            tick(1);
            seen = (sel == 0) ? chk_done_r : tx_active_r;
        end
        seen = (seen === 1'b1);
    endtask
    task automatic poll_answer();
        logic [7:0]  rq[$];
        logic [7:0]  ex[$];
        logic [15:0] c;
        logic        seen;
        reader_inst.send_frame({`CMD_POLL, 8'hff, 8'hff, 8'h00, 8'h00}, 16'h0000);
        watch(1, 200, seen);
        check(seen, 1'b1);
        reader_inst.rcv(rq);
        ex = {`RSP_POLL};
        for (int i = 7; i >= 0; i--) ex.push_back(card_identifier_area[i*8 +: 8]);
        ex = {ex, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, response_time_params[15:8],
              response_time_params[7:0], 8'hff};
        c = reader_inst.crc_byte(16'h0000, 8'(ex.size() + 1));
        foreach (ex[i]) c = reader_inst.crc_byte(c, ex[i]);
        ex = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hb2, 8'h4d, 8'(ex.size() + 1),
              ex, c[15:8], c[7:0]};
        check(rq.size(), ex.size());
        foreach (ex[i]) if (i < rq.size()) check(rq[i], ex[i]);
        $display("Poll answer test done");
    endtask
    task automatic poll_gate(input logic [15:0] sc, input logic [15:0] req, input logic exp);
        logic seen;
        stored_system_code = sc;
        reader_inst.send_frame({`CMD_POLL, req[15:8], req[7:0], 8'h00, 8'h00}, 16'h0000);
        watch(1, 200, seen);
        check(seen, exp);
        pulse_reset();
        $display("Poll gate test done");
    endtask
    task automatic drop_case(input logic [15:0] cx, input int n);
        logic seen;
        int   d0;
        d0 = drops;
        q = {};
        repeat (n) q.push_back(`CMD_READ);
        reader_inst.send_frame(q, cx);
        watch(1, 100, seen);
        check({seen, 8'(drops - d0)}, {1'b0, 8'h01});
        $display("Drop test done");
    endtask
    task automatic list_case(input logic [7:0] cmd, input int ns, input int nb,
        input logic [7:0] b0, input logic [7:0] b2, input logic [7:0] st, input logic [7:0] sp,
        input int pi, input logic [7:0] exp2, input logic tn);
        logic seen;
        q = {cmd};
        repeat (8) q.push_back(8'h11);
        q.push_back(8'(ns));
        repeat (ns) q = {q, 8'h0b, 8'h00};
        q.push_back(8'(nb));
        for (int i = 0; i < nb; i++) begin
            q = {q, b0, 8'(st + 8'(i) * sp)};
            if (!b0[7]) q.push_back(b2);
        end
        if (pi >= 0) q[pi] = q[pi] ^ 8'h04;
        reader_inst.send_frame(q, 16'h0000);
        watch(0, 100, seen);
        check(seen, 1'b1);
        check({chk_status1_r, chk_status2_r}, {exp2 == 8'h00 ? `ST_OK : `ST_FAIL, exp2});
        if (exp2 == 8'h00) check(chk_tunnel_r, tn);
        watch(1, 4, seen);
        check(seen, exp2 != 8'h00);
        pulse_reset();
        $display("List test done");
    endtask
    // First preamble bit is zero, so the line rises one half period in
    task automatic rate_case(input logic r);
        logic seen;
        int   n;
        rate_424 = r;
        stored_system_code = 16'h1234;
        reader_inst.send_frame({`CMD_POLL, 8'hff, 8'hff, 8'h00, 8'h00}, 16'h0000);
        watch(1, 200, seen);
        check(seen, 1'b1);
        n = 0;
        while (tx_out_r !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        check(n, r ? `HALF_HI : `HALF_LO);
        pulse_reset();
        rate_424 = 1'b1;
        $display("Rate test done");
    endtask
    // Bound above the summed frame and answer times, mostly the full poll answer
    initial begin
        repeat (125000) @(posedge clock);
        err_total++;
        close_out();
    end
    initial begin
        tick(20);
        reset_n = 1'b1;
        tick(3);
        poll_answer();
        poll_gate(16'h5678, 16'hffff, 1'b1);
        poll_gate(16'hab34, 16'haaff, 1'b0);
        poll_gate(16'haa34, 16'haaff, 1'b1);
        poll_gate(16'h1234, 16'h1235, 1'b0);
        poll_gate(16'h1234, 16'h1234, 1'b1);
        rate_case(1'b0);
        rate_case(1'b1);
        drop_case(16'h0100, 3);
        drop_case(16'h0000, 0);
        list_case(`CMD_READ, 0, 1, 8'h80, 0, 1, 1, -1, `ST_SVC_CNT, 0);
        list_case(`CMD_READ, 16, 1, 8'h80, 0, 1, 1, -1, `ST_SVC_CNT, 0);
        list_case(`CMD_WRITE, 12, 1, 8'h80, 0, 1, 1, -1, `ST_SVC_CNT, 0);
        list_case(`CMD_READ, 2, 1, 8'h80, 0, 1, 1, 12, `ST_SVC_DIFF, 0);
        list_case(`CMD_READ, 1, 1, 8'h90, 0, 1, 1, -1, `ST_BLK_SPEC, 0);
        list_case(`CMD_READ, 1, 1, 8'h00, 8'h08, 1, 1, -1, `ST_BLK_SPEC, 0);
        list_case(`CMD_READ, 1, 1, 8'h00, 8'h03, 1, 1, -1, `ST_BLK_SPEC, 0);
        list_case(`CMD_READ, 1, 2, 8'h00, 8'h00, 1, 1, -1, `ST_OK, 0);
        list_case(`CMD_READ, 1, 2, 8'h00, 8'h04, 5, 2, -1, `ST_BLK_SPEC, 0);
        list_case(`CMD_READ, 1, 3, 8'h00, 8'h04, 8'hff, 1, -1, `ST_OK, 1);
        list_case(`CMD_READ, 1, 3, 8'h80, 0, 9, 8'hff, -1, `ST_OK, 0);
        list_case(`CMD_READ, 1, 2, 8'h00, 8'h04, 1, 1, 18, `ST_BLK_SPEC, 0);
        list_case(`CMD_READ, 1, 1, 8'h80, 0, 32, 1, -1, `ST_BLK_SPEC, 0);
        list_case(`CMD_READ, 1, 13, 8'h80, 0, 0, 1, -1, `ST_OK, 0);
        list_case(`CMD_READ, 1, 14, 8'h80, 0, 0, 1, -1, `ST_BLK_CNT, 0);
        list_case(`CMD_READ, 1, 16, 8'h00, 8'h04, 0, 1, -1, `ST_BLK_CNT, 0);
        list_case(`CMD_WRITE, 8, 12, 8'h80, 0, 0, 1, -1, `ST_OK, 0);
        list_case(`CMD_WRITE, 9, 12, 8'h80, 0, 0, 1, -1, `ST_BLK_CNT, 0);
        close_out();
    end
endmodule
